// ==== common/adc_seq_pkg.sv ====
// Purpose: shared constants for the converter sequence control block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   all register offsets are byte addresses on the register bus
package adc_seq_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CONV_CTRL_TWO   = 8'h00;
  localparam logic [7:0] OFF_CONV_CTRL_THREE = 8'h04;
  localparam logic [7:0] OFF_CONV_CTRL_FOUR  = 8'h08;
  localparam logic [7:0] OFF_CONV_CTRL_FIVE  = 8'h0c;
  localparam logic [7:0] OFF_CONV_STATUS     = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK        = 8'h14;
  localparam logic [7:0] OFF_CONV_TEST_REG   = 8'h18;
  localparam logic [7:0] OFF_RESULT_BASE     = 8'h20;
  localparam logic [7:0] OFF_RESULT_LAST     = 8'h3c;
  // ==========================================================
  // field positions
  localparam int BIT_JUSTIFY      = 0;  // conv_ctrl_two
  localparam int BIT_WAIT_HALT    = 1;
  localparam int BIT_SIGNED       = 2;
  localparam int BIT_SINGLE_CONV  = 0;  // conv_ctrl_three
  localparam int BIT_FIFO_MODE    = 1;
  localparam int BIT_INT_REF      = 3;  // conv_ctrl_five, channel in [2:0]
  localparam int BIT_MULTI        = 4;
  localparam int BIT_SCAN         = 5;
  localparam int BIT_LONG_SEQ     = 6;
  localparam int BIT_SEQ_DONE     = 0;  // status and mask
  localparam int BIT_CONV_DONE    = 1;
  localparam int BIT_TEST_RESET   = 0;  // conv_test_reg write
  localparam int STATUS_W         = 2;
  localparam int PRESCALE_W       = 5;
  localparam int RESULT_W         = 10;
  localparam int CHAN_W           = 3;
  // ==========================================================
  // reset values, predecessor compatible
  localparam logic [7:0] RST_CTRL_TWO   = 8'h00;
  localparam logic [7:0] RST_CTRL_THREE = 8'h00;
  localparam logic [7:0] RST_CTRL_FOUR  = 8'h01;
  localparam logic [7:0] RST_CTRL_FIVE  = 8'h00;
  // sequence lengths
  localparam logic [3:0] LEN_SINGLE = 4'h1;
  localparam logic [3:0] LEN_SHORT  = 4'h4;
  localparam logic [3:0] LEN_LONG   = 4'h8;
  // ==========================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_PACE  = 3'b010,
    SEQ_CONV  = 3'b100
  } seq_state_t;
endpackage

// ==== src/adc_sequence_control.sv ====
// Purpose: sequencing and register logic of the analogue_converter
// Assumes: converter core answers each CONV_START with one CONV_DONE pulse
// Notes:   AXI4-Lite slave; one write and one read under way at a time
`timescale 1ns/1ns
module adc_sequence_control #(
  parameter int NUM_RESULTS = 8
) (
  input  wire logic                              CLK_SYS,
  input  wire logic                              NRST,
  input  wire logic                              WAIT_MODE,
  input  wire logic                              S_AXI_AWVALID,
  output logic                                   S_AXI_AWREADY,
  input  wire logic [7:0]                        S_AXI_AWADDR,
  input  wire logic                              S_AXI_WVALID,
  output logic                                   S_AXI_WREADY,
  input  wire logic [31:0]                       S_AXI_WDATA,
  input  wire logic [3:0]                        S_AXI_WSTRB,
  output logic                                   S_AXI_BVALID,
  input  wire logic                              S_AXI_BREADY,
  output logic [1:0]                             S_AXI_BRESP,
  input  wire logic                              S_AXI_ARVALID,
  output logic                                   S_AXI_ARREADY,
  input  wire logic [7:0]                        S_AXI_ARADDR,
  output logic                                   S_AXI_RVALID,
  input  wire logic                              S_AXI_RREADY,
  output logic [31:0]                            S_AXI_RDATA,
  output logic [1:0]                             S_AXI_RRESP,
  output logic                                   CONV_START,
  output logic [adc_seq_pkg::CHAN_W:0]           CONV_CHAN,
  input  wire logic                              CONV_DONE,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0]  CONV_DATA,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0]  CONV_SAR,
  output logic                                   IRQ
);
  localparam int RW = adc_seq_pkg::RESULT_W;
  localparam int CW = adc_seq_pkg::CHAN_W;
  localparam int PW = adc_seq_pkg::PRESCALE_W;
  localparam int SW = adc_seq_pkg::STATUS_W;

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic                           aw_held;
    logic [7:0]                     aw_addr;
    logic                           w_held;
    logic [31:0]                    w_data;
    logic [3:0]                     w_strb;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           rvalid;
    logic [31:0]                    rdata;
    logic [1:0]                     rresp;
    logic [7:0]                     ctrl_two;
    logic [7:0]                     ctrl_three;
    logic [7:0]                     ctrl_four;
    logic [7:0]                     ctrl_five;
    logic [SW-1:0]                  status;
    logic [SW-1:0]                  mask;
    adc_seq_pkg::seq_state_t        seq;
    logic [PW-1:0]                  pace_cnt;
    logic [3:0]                     idx;
    logic [CW-1:0]                  wr_ptr;
    logic [NUM_RESULTS-1:0][15:0]   result;
    logic                           start;
    logic [CW:0]                    chan;
    logic                           irq;
    logic                           awready;
    logic                           wready;
    logic                           arready;
  } state_t;

  state_t cur;
  state_t next_s;

  // merge a write word into a register under the byte strobes
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge8 = strb[0] ? d[7:0] : old;
  endfunction

  // justification and sign handling of one raw result
  function automatic logic [15:0] format_result(input logic [RW-1:0] d,
                                                input logic justify,
                                                input logic signed_mode);
    logic [RW-1:0] v;
    v = signed_mode ? {~d[RW-1], d[RW-2:0]} : d;
    if (justify) begin
      format_result = signed_mode ? {{(16-RW){v[RW-1]}}, v} : {{(16-RW){1'b0}}, v};
    end else begin
      format_result = {v, {(16-RW){1'b0}}};
    end
  endfunction

  logic [3:0]    seq_len;
  logic [CW-1:0] rd_index;
  logic          do_write;
  logic          wr_two;
  logic          wr_three;
  logic          wr_four;
  logic          wr_five;
  logic          wr_status;
  logic          wr_test;
  logic          restart;
  logic          abort;
  logic          seq_end;
  logic          halted;
  logic          w_mapped;
  logic          r_mapped;
  logic [31:0]   rd_word;
  logic [CW-1:0] slot;
  logic [CW-1:0] chan_step;

  always_comb begin
    next_s = cur;
    next_s.start = 1'b0;

    // ==========================================================
    // sequence length
    if (cur.ctrl_three[adc_seq_pkg::BIT_SINGLE_CONV]) begin
      seq_len = adc_seq_pkg::LEN_SINGLE;
    end else if (cur.ctrl_five[adc_seq_pkg::BIT_LONG_SEQ]) begin
      seq_len = adc_seq_pkg::LEN_LONG;
    end else begin
      seq_len = adc_seq_pkg::LEN_SHORT;
    end

    // ==========================================================
    // write channels
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_s.w_held = 1'b1;
      next_s.w_data = S_AXI_WDATA;
      next_s.w_strb = S_AXI_WSTRB;
    end
    do_write  = cur.aw_held && cur.w_held && !cur.bvalid;
    wr_two    = do_write && cur.aw_addr == adc_seq_pkg::OFF_CONV_CTRL_TWO;
    wr_three  = do_write && cur.aw_addr == adc_seq_pkg::OFF_CONV_CTRL_THREE;
    wr_four   = do_write && cur.aw_addr == adc_seq_pkg::OFF_CONV_CTRL_FOUR;
    wr_five   = do_write && cur.aw_addr == adc_seq_pkg::OFF_CONV_CTRL_FIVE;
    wr_status = do_write && cur.aw_addr == adc_seq_pkg::OFF_CONV_STATUS;
    wr_test   = do_write && cur.aw_addr == adc_seq_pkg::OFF_CONV_TEST_REG;
    w_mapped  = wr_two || wr_three || wr_four || wr_five || wr_status || wr_test
                || cur.aw_addr == adc_seq_pkg::OFF_IRQ_MASK
                || (cur.aw_addr >= adc_seq_pkg::OFF_RESULT_BASE
                    && cur.aw_addr <= adc_seq_pkg::OFF_RESULT_LAST
                    && cur.aw_addr[1:0] == 2'b00);
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = w_mapped ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
    end
    if (cur.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    // control two and three only update settings; a run in flight keeps going
    if (wr_two) begin
      next_s.ctrl_two = merge8(cur.ctrl_two, cur.w_data, cur.w_strb);
    end
    if (wr_three) begin
      next_s.ctrl_three = merge8(cur.ctrl_three, cur.w_data, cur.w_strb);
    end
    if (wr_four) begin
      next_s.ctrl_four = merge8(cur.ctrl_four, cur.w_data, cur.w_strb);
    end
    if (wr_five) begin
      next_s.ctrl_five = merge8(cur.ctrl_five, cur.w_data, cur.w_strb);
    end
    if (do_write && cur.aw_addr == adc_seq_pkg::OFF_IRQ_MASK && cur.w_strb[0]) begin
      next_s.mask = cur.w_data[SW-1:0];
    end

    // ==========================================================
    // sequencer
    restart = (wr_four || wr_five) && cur.w_strb[0];
    abort   = wr_test && cur.w_strb[0] && cur.w_data[adc_seq_pkg::BIT_TEST_RESET];
    halted  = WAIT_MODE && cur.ctrl_two[adc_seq_pkg::BIT_WAIT_HALT];
    seq_end = 1'b0;
    slot    = cur.ctrl_three[adc_seq_pkg::BIT_FIFO_MODE] ? cur.wr_ptr : cur.idx[CW-1:0];
    // single channel mode converts the start channel at every step of the run
    chan_step = cur.ctrl_five[adc_seq_pkg::BIT_MULTI] ? cur.idx[CW-1:0] : '0;
    if (cur.status != '0 && wr_status && cur.w_strb[0]) begin
      next_s.status = cur.status & ~cur.w_data[SW-1:0];
    end
    unique case (cur.seq)
      adc_seq_pkg::SEQ_IDLE: begin
      end
      adc_seq_pkg::SEQ_PACE: begin
        // the prescaler in control four paces each conversion start
        if (halted) begin
          next_s.pace_cnt = cur.pace_cnt;
        end else if (cur.pace_cnt >= cur.ctrl_four[PW-1:0]) begin
          next_s.pace_cnt = '0;
          next_s.start    = 1'b1;
          next_s.seq      = adc_seq_pkg::SEQ_CONV;
          // channel steps on from the chosen start, wrapping at eight
          next_s.chan = {cur.ctrl_five[adc_seq_pkg::BIT_INT_REF],
                         CW'(cur.ctrl_five[CW-1:0] + chan_step)};
        end else begin
          next_s.pace_cnt = PW'(cur.pace_cnt + 1'b1);
        end
      end
      adc_seq_pkg::SEQ_CONV: begin
        if (CONV_DONE) begin
          next_s.result[slot] = format_result(CONV_DATA,
                                  cur.ctrl_two[adc_seq_pkg::BIT_JUSTIFY],
                                  cur.ctrl_two[adc_seq_pkg::BIT_SIGNED]);
          next_s.wr_ptr = CW'(cur.wr_ptr + 1'b1);
          next_s.status[adc_seq_pkg::BIT_CONV_DONE] = 1'b1;
          if (cur.idx + 1'b1 >= seq_len) begin
            seq_end    = 1'b1;
            next_s.idx = '0;
            next_s.status[adc_seq_pkg::BIT_SEQ_DONE] = 1'b1;
            next_s.seq = cur.ctrl_five[adc_seq_pkg::BIT_SCAN] ? adc_seq_pkg::SEQ_PACE
                                                               : adc_seq_pkg::SEQ_IDLE;
          end else begin
            next_s.idx = 4'(cur.idx + 1'b1);
            next_s.seq = adc_seq_pkg::SEQ_PACE;
          end
        end
      end
    endcase
    // a start raised by the run being cut would reach the core after the cut
    // and leave it converting a channel that nobody waits for
    if (restart || abort) begin
      next_s.start = 1'b0;
      next_s.chan  = cur.chan;
    end
    if (restart) begin
      next_s.seq      = adc_seq_pkg::SEQ_PACE;
      next_s.idx      = '0;
      next_s.pace_cnt = '0;
      next_s.wr_ptr   = '0;
      next_s.status   = '0;
    end else if (abort) begin
      next_s.seq      = adc_seq_pkg::SEQ_IDLE;
      next_s.idx      = '0;
      next_s.pace_cnt = '0;
      next_s.wr_ptr   = '0;
      next_s.status   = '0;
    end

    // ==========================================================
    // read channel
    rd_index = CW'(S_AXI_ARADDR[4:2]);
    r_mapped = 1'b1;
    unique case (S_AXI_ARADDR)
      adc_seq_pkg::OFF_CONV_CTRL_TWO:   rd_word = {24'h0, cur.ctrl_two};
      adc_seq_pkg::OFF_CONV_CTRL_THREE: rd_word = {24'h0, cur.ctrl_three};
      adc_seq_pkg::OFF_CONV_CTRL_FOUR:  rd_word = {24'h0, cur.ctrl_four};
      adc_seq_pkg::OFF_CONV_CTRL_FIVE:  rd_word = {24'h0, cur.ctrl_five};
      adc_seq_pkg::OFF_CONV_STATUS:     rd_word = {{(32-SW){1'b0}}, cur.status};
      adc_seq_pkg::OFF_IRQ_MASK:        rd_word = {{(32-SW){1'b0}}, cur.mask};
      adc_seq_pkg::OFF_CONV_TEST_REG:   rd_word = {{(32-RW){1'b0}}, CONV_SAR};
      default: begin
        if (S_AXI_ARADDR >= adc_seq_pkg::OFF_RESULT_BASE
            && S_AXI_ARADDR <= adc_seq_pkg::OFF_RESULT_LAST
            && S_AXI_ARADDR[1:0] == 2'b00) begin
          rd_word = {16'h0, cur.result[rd_index]};
        end else begin
          rd_word  = 32'h0;
          r_mapped = 1'b0;
        end
      end
    endcase
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_word;
      next_s.rresp  = r_mapped ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
    end else if (cur.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end

    // ==========================================================
    // interrupt: sticky status gated by mask
    next_s.irq = |(next_s.status & next_s.mask);
    // readies are registered copies so no bus output passes through a gate
    next_s.awready = !next_s.aw_held;
    next_s.wready  = !next_s.w_held;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cur            <= '0;
      cur.ctrl_two   <= adc_seq_pkg::RST_CTRL_TWO;
      cur.ctrl_three <= adc_seq_pkg::RST_CTRL_THREE;
      cur.ctrl_four  <= adc_seq_pkg::RST_CTRL_FOUR;
      cur.ctrl_five  <= adc_seq_pkg::RST_CTRL_FIVE;
      cur.seq        <= adc_seq_pkg::SEQ_IDLE;
    end else begin
      cur <= next_s;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign S_AXI_AWREADY = cur.awready;
  assign S_AXI_WREADY  = cur.wready;
  assign S_AXI_BVALID  = cur.bvalid;
  assign S_AXI_BRESP   = cur.bresp;
  assign S_AXI_ARREADY = cur.arready;
  assign S_AXI_RVALID  = cur.rvalid;
  assign S_AXI_RDATA   = cur.rdata;
  assign S_AXI_RRESP   = cur.rresp;
  assign CONV_START    = cur.start;
  assign CONV_CHAN     = cur.chan;
  assign IRQ           = cur.irq;
endmodule

// ==== sim/adc_seq_props.sv ====
// Purpose: port-level checks of the converter sequence control block
// Assumes: bench keeps WAIT_MODE low around control four and five writes
// Notes:   write decode is rebuilt here from the bus handshakes
`timescale 1ns/1ns
module adc_seq_props (
  input wire logic                             CLK_SYS,
  input wire logic                             NRST,
  input wire logic                             S_AXI_AWVALID,
  input wire logic                             S_AXI_AWREADY,
  input wire logic [7:0]                       S_AXI_AWADDR,
  input wire logic                             S_AXI_WVALID,
  input wire logic                             S_AXI_WREADY,
  input wire logic [31:0]                      S_AXI_WDATA,
  input wire logic                             S_AXI_BVALID,
  input wire logic                             S_AXI_ARVALID,
  input wire logic                             S_AXI_ARREADY,
  input wire logic [7:0]                       S_AXI_ARADDR,
  input wire logic [31:0]                      S_AXI_RDATA,
  input wire logic                             CONV_START,
  input wire logic [adc_seq_pkg::CHAN_W:0]     CONV_CHAN,
  input wire logic                             CONV_DONE,
  input wire logic [adc_seq_pkg::RESULT_W-1:0] CONV_SAR,
  input wire logic                             IRQ
);
  // ==========================================================
  // write decode
  logic [7:0] wa;
  logic [3:0] wd;
  logic [3:0] chan_exp;
  logic       bv_q;
  logic       first;
  logic       wdone;
  assign wdone = S_AXI_BVALID && !bv_q;
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      wa       <= 8'h00;
      wd       <= 4'h0;
      chan_exp <= 4'h0;
      bv_q     <= 1'b0;
      first    <= 1'b0;
    end else begin
      bv_q <= S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) wa <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) wd <= S_AXI_WDATA[3:0];
      if (wdone && wa == adc_seq_pkg::OFF_CONV_CTRL_FIVE) begin
        first    <= 1'b1;
        chan_exp <= wd;
      end else if (CONV_START) begin
        first <= 1'b0;
      end
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  sequence s_wr(logic [7:0] a);
    wdone && wa == a;
  endsequence
  property p_restart_four;
    s_wr(adc_seq_pkg::OFF_CONV_CTRL_FOUR) |-> ##[1:40] CONV_START;
  endproperty
  a_restart_four: assert property (p_restart_four) else $error("no restart");
  property p_restart_five;
    s_wr(adc_seq_pkg::OFF_CONV_CTRL_FIVE) |-> !IRQ ##[1:40] CONV_START;
  endproperty
  a_restart_five: assert property (p_restart_five) else $error("no clean restart");
  property p_first_chan;
    first && CONV_START |-> CONV_CHAN == chan_exp;
  endproperty
  a_first_chan: assert property (p_first_chan) else $error("wrong first channel");
  property p_chan_hold;
    !CONV_START |-> $stable(CONV_CHAN);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  property p_test_read;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == adc_seq_pkg::OFF_CONV_TEST_REG
      |=> S_AXI_RDATA == {22'h0, $past(CONV_SAR)};
  endproperty
  a_test_read: assert property (p_test_read) else $error("test read mismatch");
  property p_test_reset;
    s_wr(adc_seq_pkg::OFF_CONV_TEST_REG) ##0 wd[0] |-> !IRQ ##1 (!CONV_START) [*4];
  endproperty
  a_test_reset: assert property (p_test_reset) else $error("test reset ignored");
  property p_irq_fall;
    $fell(IRQ) |-> wdone;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("flag dropped alone");
  property p_irq_rise;
    $rose(IRQ) |-> $past(CONV_DONE) || wdone;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
endmodule
bind adc_sequence_control adc_seq_props i_adc_seq_props (.*);

// ==== sim/conv_core_model.sv ====
// Purpose: behavioural converter core facing the sequence control block
// Assumes: a new start restarts the countdown of the conversion
// Notes:   data and approximation lines never hold stale values
`timescale 1ns/1ns
module conv_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [3:0] chan,
  input  wire logic       slow,
  output logic            done,
  output logic [9:0]      data,
  output logic [9:0]      approx_register
);
  int         cnt;
  logic [2:0] ch;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 0;
      ch   <= 3'h0;
      done <= 1'b0;
      data <= 10'h000;
      approx_register  <= 10'h000;
    end else begin
      // moving pattern so a mistimed capture shows
      approx_register  <= {approx_register[8:0], ~approx_register[9]};
      done <= (cnt == 1);
      data <= (cnt == 1) ? {ch, 7'h35} : ~data;
      if (start) begin
        cnt <= slow ? 12 : 2;
        ch  <= chan[2:0];
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ==== sim/test_adc_sequence_control.sv ====
// Purpose: self-checking bench for the converter sequence control block
// Assumes: mask bit 0 routes the sequence done flag to IRQ
// Notes:   bus results are queued by the driver and checked by a monitor
`timescale 1ns/1ns
module test_adc_sequence_control;
  logic        CLK_SYS = 1'b0, NRST = 1'b0, WAIT_MODE = 1'b0, slow = 1'b0;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        CONV_START, CONV_DONE, IRQ;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, seed = 32'h6bd2;
  logic [3:0]  S_AXI_WSTRB = 4'hf, CONV_CHAN;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, bq[$];
  logic [9:0]  CONV_DATA, CONV_SAR;
  logic [33:0] rq[$];
  int          mismatches = 0, n_tests = 0, n_starts = 0, cycles = 0, s0 = 0;
  adc_sequence_control i_adc_sequence_control (.*);
  conv_core_model i_conv_core_model (.clk(CLK_SYS), .rst_n(NRST), .start(CONV_START),
    .chan(CONV_CHAN), .slow(slow), .done(CONV_DONE), .data(CONV_DATA), .approx_register(CONV_SAR));
  always #4 CLK_SYS = ~CLK_SYS;
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [33:0] res(logic [2:0] ch, logic j, logic s);
    logic [9:0] v;
    v = {ch ^ {s, 2'b00}, 7'h35};
    if (!j) return {18'h0, v, 6'h00};
    return {18'h0, {6{v[9] & s}}, v};
  endfunction
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    @(posedge CLK_SYS);
    bq.push_back(r);
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input bit approx_register = 1'b0);
    @(posedge CLK_SYS);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    rq.push_back(approx_register ? {24'h0, CONV_SAR} : e);
    do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic await_irq();
    int t = 0;
    while (IRQ !== 1'b1 && t < 3000) begin
      @(posedge CLK_SYS);
      t++;
    end
    cmp({33'h0, IRQ}, 34'h1);
  endtask
  task automatic await_starts(input int n);
    int t = 0;
    while (n_starts - s0 < n && t < 3000) begin
      @(posedge CLK_SYS);
      t++;
    end
  endtask
  // ==========================================================
  // monitor, start counter and timeout
  always @(posedge CLK_SYS) begin
    if (S_AXI_RVALID && S_AXI_RREADY) cmp({S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
    if (S_AXI_BVALID && S_AXI_BREADY) cmp({32'h0, S_AXI_BRESP}, {32'h0, bq.pop_front()});
  end
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (CONV_START === 1'b1) n_starts <= n_starts + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [2:0] ch;
    logic [3:0] c5;
    ch = 3'(rnd());
    c5 = 4'(rnd());
    repeat (3) @(posedge CLK_SYS);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    rd(8'h00, 34'h0);
    rd(8'h04, 34'h0);
    rd(8'h08, {26'h0, adc_seq_pkg::RST_CTRL_FOUR});
    rd(8'h0c, 34'h0);
    rd(8'h1c, {2'b10, 32'h0});
    wr(8'h40, 32'h1, 2'b10);
    wr(8'h14, 32'h1);
    wr(8'h08, {30'h0, c5[1:0]});
    await_irq();
    s0 = n_starts;
    wr(8'h0c, {27'h0, 1'b1, c5[3], ch});
    await_irq();
    cmp(34'(n_starts - s0), 34'd4);
    rd(8'h10, 34'h3);
    for (int i = 0; i < 4; i++) rd(8'h20 + 8'(4 * i), res(3'(ch + i), 1'b0, 1'b0));
    wr(8'h14, 32'h0);
    cmp({33'h0, IRQ}, 34'h0);
    wr(8'h14, 32'h1);
    cmp({33'h0, IRQ}, 34'h1);
    wr(8'h10, 32'h3);
    rd(8'h10, 34'h0);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, {29'h0, k[1], 1'b0, k[0]});
      wr(8'h04, {31'h0, k == 3});
      s0 = n_starts;
      wr(8'h0c, {25'h0, k[0], 3'h0, ch});
      await_irq();
      cmp(34'(n_starts - s0), (k == 3) ? 34'd1 : (k[0] ? 34'd8 : 34'd4));
      rd(8'h20, res(ch, k[0], k[1]));
    end
    wr(8'h04, 32'h0);
    slow <= 1'b1;
    s0 = n_starts;
    wr(8'h0c, 32'h40);
    await_starts(2);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h0);
    await_irq();
    cmp(34'(n_starts - s0), 34'd8);
    s0 = n_starts;
    wr(8'h0c, 32'h40);
    await_starts(2);
    wr(8'h08, {30'h0, c5[1:0]});
    await_irq();
    cmp(34'(n_starts - s0), 34'd10);
    wr(8'h00, 32'h2);
    s0 = n_starts;
    wr(8'h0c, 32'h40);
    await_starts(1);
    WAIT_MODE <= 1'b1;
    // the run must sit still while the system waits
    repeat (60) @(posedge CLK_SYS);
    cmp(34'(n_starts - s0), 34'd1);
    WAIT_MODE <= 1'b0;
    await_irq();
    cmp(34'(n_starts - s0), 34'd8);
    slow <= 1'b0;
    wr(8'h04, 32'h2);
    wr(8'h0c, {26'h0, 3'h6, ch});
    await_irq();
    wr(8'h10, 32'h1);
    cmp({33'h0, IRQ}, 34'h0);
    await_irq();
    for (int i = 0; i < 4; i++) rd(8'h30 + 8'(4 * i), res(3'(ch + i), 1'b0, 1'b0));
    rd(8'h18, 34'h0, 1'b1);
    wr(8'h18, 32'h1);
    rd(8'h10, 34'h0);
    s0 = n_starts;
    repeat (40) @(posedge CLK_SYS);
    cmp(34'(n_starts - s0), 34'd0);
    close_out();
  end
endmodule
